// File: hw/pcr_ctrl_regs.sv
/*
  phy control registers one and two with the link, crossover, receive,
  duplex and transmit behaviour they steer.
  assumes clk is the transmit nibble clock, all inputs synchronous to it,
  and a register port master that never strobes read and write together.
*/
// Contract
// - when control-one bit 8 is set a link-down event starts a cable test.
// - normally the link status drops about 250 us after signal loss.
// - control-one bit 7 holds the link up a few more ms through short loss.
// - control-one bit 5 resolves crossover robustly and avoids deadlock.
// - with control-one bit 1 clear receive valid rises only after /J/K/.
// - with bit 1 set receive valid rises on /J/ and a missing /K/ errors.
// - control-two bit 5 forces full duplex against a forced 100 partner while an_enable or forced_100 is set.
// - control-two bit 2 reports symbol errors seen in the idle state.
// - with control-two bit 1 clear an odd-nibble end adds one error cycle.
// - the odd-nibble default follows pin mode and the strap after reset.
// - reset gives 0000h to control-one and 0102h to control-two.
`timescale 1ns/1ps
`default_nettype none

module pcr_ctrl_regs
  import pcr_pkg::*;
#(
  parameter int LINK_DROP_CYC = `PCR_LINK_DROP_US * `PCR_CLK_MHZ,
  parameter int RECOVERY_CYC  = `PCR_RECOVERY_US * `PCR_CLK_MHZ,
  parameter int XOVER_CYC     = `PCR_XOVER_US * `PCR_CLK_MHZ,
  parameter int TMR_W         = `PCR_TMR_W
) (
  input  wire logic           clk,
  input  wire logic           sys_rst,
  input  wire pcr_req_type    reg_req,
  output logic [15:0]         reg_rdata,
  input  wire logic           standard_pinout_mode,
  input  wire logic           configuration_strap_one,
  input  wire logic           signal_ok,
  output logic                link_up,
  output logic                auto_cable_reflectometry,
  output logic                mdix_sel,
  input  wire logic           an_enable,
  input  wire logic           forced_100,
  input  wire logic           partner_forced_100,
  input  wire logic           std_full_duplex,
  output logic                full_duplex,
  input  wire pcr_rx_sym_type rx_sym,
  output logic                rx_dv,
  output logic                rx_er,
  input  wire logic           tx_en_in,
  input  wire logic           tx_er_in,
  output logic                tx_en_out,
  output logic                tx_er_out
);

  localparam int MAX_LOSS = LINK_DROP_CYC + RECOVERY_CYC;
  localparam int MAX_XOV  = XOVER_CYC + (1 << `PCR_LFSR_W);
  if (LINK_DROP_CYC < 1 || RECOVERY_CYC < 1 || XOVER_CYC < 1 ||
      MAX_LOSS >= (1 << TMR_W) || MAX_XOV >= (1 << TMR_W)) begin : g_bad
    $error("pcr_ctrl_regs: timing counts out of range for TMR_W");
  end

  logic [15:0]            ctrl_one_reg;
  logic [15:0]            ctrl_one_next;
  logic [15:0]            ctrl_two_reg;
  logic [15:0]            rdata_reg;
  logic [15:0]            rd_value;
  logic                   strap_done_reg;
  logic                   hit_one;
  logic                   hit_two;
  logic                   auto_refl_en;
  logic                   recovery_en;
  logic                   robust_en;
  logic                   early_en;
  logic                   ext_fdx_en;
  logic                   idle_err_en;
  logic                   odd_nib_en;
  logic                   strap_odd_dis;
  logic                   link_up_reg;
  logic                   rec_lat_reg;
  logic                   refl_reg;
  logic                   loss_run;
  logic                   loss_expired;
  logic [TMR_W-1:0]       loss_limit;
  logic                   xov_run;
  logic                   xov_expired;
  logic [TMR_W-1:0]       xov_limit;
  logic                   mdix_reg;
  logic [`PCR_LFSR_W-1:0] lfsr_reg;
  logic [`PCR_LFSR_W-1:0] lfsr_next;
  logic [`PCR_LFSR_W-1:0] xov_jit_reg;
  logic                   fdx_reg;
  logic                   fdx_next;
  pcr_rx_state_type       rx_state_reg;
  pcr_rx_state_type       rx_state_next;
  logic                   rx_dv_reg;
  logic                   rx_dv_next;
  logic                   rx_er_reg;
  logic                   rx_er_next;
  logic                   tx_en_reg;
  logic                   tx_er_reg;
  logic                   tx_prev_reg;
  logic                   odd_reg;
  logic                   odd_end;
  logic [31:0]            loss_cnt_reg;

  // register decode
  assign hit_one  = reg_req.addr == `PCR_OFF_CTRL_ONE;
  assign hit_two  = reg_req.addr == `PCR_OFF_CTRL_TWO;
  assign rd_value = hit_one ? ctrl_one_reg : (hit_two ? ctrl_two_reg : '0);
  assign ctrl_one_next = reg_req.wdata & `PCR_WMASK_CTRL_ONE;
  assign strap_odd_dis = standard_pinout_mode ? 1'b1 : configuration_strap_one;
  assign auto_refl_en = ctrl_one_reg[`PCR_BIT_AUTO_REFL];
  assign recovery_en  = ctrl_one_reg[`PCR_BIT_LL_RECOVERY];
  assign robust_en    = ctrl_one_reg[`PCR_BIT_ROBUST_XOV];
  assign early_en     = ctrl_one_reg[`PCR_BIT_EARLY_RXDV];
  assign ext_fdx_en   = ctrl_two_reg[`PCR_BIT_EXT_FDX];
  assign idle_err_en  = ctrl_two_reg[`PCR_BIT_IDLE_SYMERR];
  assign odd_nib_en   = !ctrl_two_reg[`PCR_BIT_ODD_NIB_DIS];
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_one_reg   <= `PCR_RST_CTRL_ONE;
      ctrl_two_reg   <= `PCR_RST_CTRL_TWO;
      strap_done_reg <= 1'b0;
      rdata_reg      <= '0;
    end else begin
      strap_done_reg <= 1'b1;
      rdata_reg      <= reg_req.rd ? rd_value : '0;
      if (reg_req.wr && hit_one) begin
        ctrl_one_reg <= ctrl_one_next;
      end
      if (reg_req.wr && hit_two) begin
        ctrl_two_reg <= reg_req.wdata;
      end else if (!strap_done_reg) begin
        ctrl_two_reg[`PCR_BIT_ODD_NIB_DIS] <= strap_odd_dis;
      end
    end
  end

  assign loss_run   = link_up_reg && !signal_ok;
  assign loss_limit = rec_lat_reg ? TMR_W'(MAX_LOSS) : TMR_W'(LINK_DROP_CYC);
  pcr_timer #(
    .CNT_W   (TMR_W)
  ) u_loss_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (loss_run),
    .limit   (loss_limit),
    .expired (loss_expired)
  );

  assign xov_run   = !link_up_reg && !signal_ok;
  assign xov_limit = TMR_W'(XOVER_CYC) + TMR_W'(xov_jit_reg);
  assign lfsr_next = {lfsr_reg[6:0],
                      lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
  pcr_timer #(
    .CNT_W   (TMR_W)
  ) u_xov_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (xov_run),
    .limit   (xov_limit),
    .expired (xov_expired)
  );
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      link_up_reg <= 1'b0;
      rec_lat_reg <= 1'b0;
      refl_reg    <= 1'b0;
      mdix_reg    <= 1'b0;
      lfsr_reg    <= `PCR_LFSR_SEED;
      xov_jit_reg <= '0;
    end else begin
      lfsr_reg <= lfsr_next;
      xov_jit_reg <= (xov_expired || !xov_run) ?
                     (robust_en ? lfsr_reg : '0) : xov_jit_reg;
      refl_reg <= loss_expired && auto_refl_en;
      if (signal_ok) begin
        rec_lat_reg <= recovery_en;
        link_up_reg <= 1'b1;
      end else if (loss_expired) begin
        link_up_reg <= 1'b0;
      end
      if (xov_expired) begin
        mdix_reg <= !mdix_reg;
      end
    end
  end

  assign fdx_next = (ext_fdx_en && (an_enable || forced_100) &&
                     partner_forced_100) || std_full_duplex;
  always_comb begin
    rx_state_next = rx_state_reg;
    rx_dv_next    = rx_dv_reg;
    rx_er_next    = 1'b0;
    if (rx_sym.valid) begin
      case (rx_state_reg)
        PCR_RX_IDLE: begin
          rx_dv_next = 1'b0;
          if (rx_sym.code == PCR_SYM_J) begin
            rx_state_next = PCR_RX_GOT_J;
            rx_dv_next    = early_en;
          end else if (rx_sym.code != PCR_SYM_IDLE) begin
            rx_er_next = idle_err_en;
          end
        end
        PCR_RX_GOT_J: begin
          if (rx_sym.code == PCR_SYM_K) begin
            rx_state_next = PCR_RX_FRAME;
            rx_dv_next    = 1'b1;
          end else begin
            rx_state_next = PCR_RX_IDLE;
            rx_dv_next    = 1'b0;
            rx_er_next    = early_en;
          end
        end
        PCR_RX_FRAME: begin
          if (rx_sym.code == PCR_SYM_T) begin
            rx_state_next = PCR_RX_IDLE;
            rx_dv_next    = 1'b0;
          end else if (rx_sym.code == PCR_SYM_IDLE) begin
            rx_state_next = PCR_RX_IDLE;
            rx_dv_next    = 1'b0;
            rx_er_next    = 1'b1;
          end else if (rx_sym.code == PCR_SYM_BAD) begin
            rx_er_next = 1'b1;
          end
        end
        default: begin
          rx_state_next = PCR_RX_IDLE;
          rx_dv_next    = 1'b0;
        end
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_state_reg <= PCR_RX_IDLE;
      rx_dv_reg    <= 1'b0;
      rx_er_reg    <= 1'b0;
      fdx_reg      <= 1'b0;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_dv_reg    <= rx_dv_next;
      rx_er_reg    <= rx_er_next;
      fdx_reg      <= fdx_next;
    end
  end

  assign odd_end = odd_nib_en && tx_prev_reg && !tx_en_in && odd_reg;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_prev_reg <= 1'b0;
      odd_reg     <= 1'b0;
      tx_en_reg   <= 1'b0;
      tx_er_reg   <= 1'b0;
    end else begin
      tx_prev_reg <= tx_en_in;
      odd_reg     <= tx_en_in ? !odd_reg : 1'b0;
      tx_en_reg   <= tx_en_in || odd_end;
      tx_er_reg   <= (tx_en_in && tx_er_in) || odd_end;
    end
  end

  assign reg_rdata                = rdata_reg;
  assign link_up                  = link_up_reg;
  assign auto_cable_reflectometry = refl_reg;
  assign mdix_sel                 = mdix_reg;
  assign full_duplex              = fdx_reg;
  assign rx_dv                    = rx_dv_reg;
  assign rx_er                    = rx_er_reg;
  assign tx_en_out                = tx_en_reg;
  assign tx_er_out                = tx_er_reg;
  // loss length seen by the checks
  always_ff @(posedge clk) begin
    if (sys_rst || !loss_run) begin
      loss_cnt_reg <= '0;
    end else begin
      loss_cnt_reg <= loss_cnt_reg + 32'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_refl_start;
    loss_expired && auto_refl_en |=> auto_cable_reflectometry;
  endproperty
  a_refl_start: assert property (p_refl_start)
    else $error("cable test did not start after link drop");
  property p_refl_quiet;
    auto_cable_reflectometry |-> $past(auto_refl_en) && !link_up_reg;
  endproperty
  a_refl_quiet: assert property (p_refl_quiet)
    else $error("cable test started while disabled");
  property p_drop_time;
    $fell(link_up_reg) |->
      loss_cnt_reg == 32'(LINK_DROP_CYC) + 32'h2 ||
      (rec_lat_reg && loss_cnt_reg == 32'(MAX_LOSS) + 32'h2);
  endproperty
  a_drop_time: assert property (p_drop_time)
    else $error("link dropped at the wrong time");
  property p_recovery_hold;
    rec_lat_reg && loss_run && loss_cnt_reg <= 32'(MAX_LOSS) |=> link_up_reg;
  endproperty
  a_recovery_hold: assert property (p_recovery_hold)
    else $error("link dropped inside recovery time");
  property p_jk_order;
    $rose(rx_dv_reg) && !$past(early_en) |->
      $past(rx_state_reg == PCR_RX_GOT_J && rx_sym.code == PCR_SYM_K);
  endproperty
  a_jk_order: assert property (p_jk_order)
    else $error("receive valid rose before /K/");
  property p_early_dv;
    rx_sym.valid && rx_state_reg == PCR_RX_IDLE &&
      rx_sym.code == PCR_SYM_J && early_en
      ##1 rx_sym.valid && rx_sym.code != PCR_SYM_K
      |-> rx_dv_reg ##1 rx_er_reg && !rx_dv_reg;
  endproperty
  a_early_dv: assert property (p_early_dv)
    else $error("early receive valid or missing /K/ error wrong");
  property p_fdx;
    ext_fdx_en && forced_100 && partner_forced_100 |=> full_duplex;
  endproperty
  a_fdx: assert property (p_fdx)
    else $error("extended full duplex not applied");
  property p_idle_err;
    rx_sym.valid && rx_state_reg == PCR_RX_IDLE &&
      rx_sym.code == PCR_SYM_BAD |=> rx_er_reg == $past(idle_err_en);
  endproperty
  a_idle_err: assert property (p_idle_err)
    else $error("idle symbol error report wrong");
  property p_odd_ext;
    odd_end |=> tx_en_out && tx_er_out ##1 (!tx_er_out || $past(tx_er_in));
  endproperty
  a_odd_ext: assert property (p_odd_ext)
    else $error("odd-nibble end not extended with error");
  property p_reserved_zero;
    (ctrl_one_reg & ~`PCR_WMASK_CTRL_ONE) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("read-only reserved bit set");
  property p_strap;
    $rose(strap_done_reg) |->
      ctrl_two_reg[`PCR_BIT_ODD_NIB_DIS] == $past(strap_odd_dis);
  endproperty
  a_strap: assert property (p_strap)
    else $error("odd-nibble default not taken from strap");

  c_link_drop: cover property ($fell(link_up_reg));
  c_early_frame: cover property (early_en && $rose(rx_dv_reg));
  c_odd_end: cover property (odd_end);
endmodule

`default_nettype wire

// File: hw/pcr_consts.svh
/*
  constants of the phy control register pair: offsets, reset values,
  field positions and timing figures.
  assumes a 50 MHz clock that follows the transmit nibble clock.
*/
`ifndef PCR_CONSTS_SVH
`define PCR_CONSTS_SVH

`define PCR_ADDR_W          5
`define PCR_DATA_W          16
`define PCR_OFF_CTRL_ONE    5'h09
`define PCR_OFF_CTRL_TWO    5'h0A
`define PCR_RST_CTRL_ONE    16'h0000
`define PCR_RST_CTRL_TWO    16'h0102
`define PCR_WMASK_CTRL_ONE  16'h03FE
`define PCR_BIT_AUTO_REFL   8
`define PCR_BIT_LL_RECOVERY 7
`define PCR_BIT_ROBUST_XOV  5
`define PCR_BIT_EARLY_RXDV  1
`define PCR_BIT_EXT_FDX     5
`define PCR_BIT_IDLE_SYMERR 2
`define PCR_BIT_ODD_NIB_DIS 1
`define PCR_LFSR_W          8
`define PCR_LFSR_SEED       8'h01
`define PCR_CLK_MHZ         50
`define PCR_LINK_DROP_US    250
`define PCR_RECOVERY_US     3000
`define PCR_XOVER_US        60
`define PCR_TMR_W           18

`endif

// File: hw/pcr_pkg.sv
/*
  types of the phy control register pair: bus request, receive symbol,
  receive state.
  assumes pcr_consts.svh on the include path.
*/
`default_nettype none
`include "pcr_consts.svh"

package pcr_pkg;

  typedef logic [`PCR_ADDR_W-1:0] pcr_addr_type;
  typedef logic [`PCR_DATA_W-1:0] pcr_data_type;

  typedef struct packed {
    pcr_addr_type addr;
    pcr_data_type wdata;
    logic         wr;
    logic         rd;
  } pcr_req_type;

  typedef enum logic [2:0] {
    PCR_SYM_IDLE,
    PCR_SYM_J,
    PCR_SYM_K,
    PCR_SYM_DATA,
    PCR_SYM_T,
    PCR_SYM_R,
    PCR_SYM_BAD
  } pcr_sym_type;

  typedef struct packed {
    logic        valid;
    pcr_sym_type code;
  } pcr_rx_sym_type;

  typedef enum logic [1:0] {
    PCR_RX_IDLE,
    PCR_RX_GOT_J,
    PCR_RX_FRAME
  } pcr_rx_state_type;

endpackage

`default_nettype wire

// File: hw/pcr_timer.sv
/*
  run timer: counts while run is high, restarts when run drops,
  pulses expired one cycle after the count reaches limit.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module pcr_timer #(
  parameter int CNT_W = 18
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             run,
  input  wire logic [CNT_W-1:0] limit,
  output logic                  expired
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             expired_reg;
  logic             hit;

  if (CNT_W < 2) begin : g_bad_width
    $error("pcr_timer: CNT_W must be at least 2");
  end

  assign hit      = run && (cnt_reg == limit);
  assign cnt_next = (!run || hit) ? '0 : cnt_reg + CNT_W'(1);
  assign expired  = expired_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_reg     <= '0;
      expired_reg <= 1'b0;
    end else begin
      cnt_reg     <= cnt_next;
      expired_reg <= hit;
    end
  end

endmodule

`default_nettype wire

// File: verif/pcr_mac_model.sv
/*
  mac transmit model: bursts of nibbles on the mii transmit side,
  with an optional error on the first nibble.
  assumes start pulses for one cycle, only while no burst runs.
*/
`timescale 1ns/1ps
`default_nettype none

module pcr_mac_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       start,
  input  wire logic [3:0] nibbles,
  input  wire logic       inject_err,
  output logic            tx_en,
  output logic            tx_er
);
  logic [3:0] rem_reg;
  logic       err_reg;

  // nibbles left in burst
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rem_reg <= 4'h0;
      err_reg <= 1'b0;
    end else if (start) begin
      rem_reg <= nibbles;
      err_reg <= inject_err;
    end else if (rem_reg != 4'h0) begin
      rem_reg <= rem_reg - 4'h1;
      err_reg <= 1'b0;
    end
  end

  assign tx_en = (rem_reg != 4'h0);
  assign tx_er = tx_en & err_reg;
endmodule

`default_nettype wire

// File: verif/pcr_ctrl_regs_test.sv
/*
  testbench of the control register pair: register port, link,
  crossover, duplex, transmit and receive behaviour.
  assumes shortened timer parameters and a 50 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pcr_consts.svh"

module pcr_ctrl_regs_test
  import pcr_pkg::*;
();
  localparam int LDROP = 20;
  localparam int RCV   = 40;
  localparam int XOV   = 10;

  logic           clk     = 1'b0;
  logic           sys_rst = 1'b1;
  pcr_req_type    req     = '0;
  logic [15:0]    rdata;
  logic           mode    = 1'b0;
  logic           strap   = 1'b1;
  logic           sig_ok  = 1'b0;
  logic           link_up;
  logic           cable_start;
  logic           mdix_sel;
  logic           an_en   = 1'b0;
  logic           f100    = 1'b0;
  logic           pf100   = 1'b0;
  logic           std_fdx = 1'b0;
  logic           fdx;
  pcr_rx_sym_type rx_sym  = '0;
  logic           rx_dv;
  logic           rx_er;
  logic           start   = 1'b0;
  logic [3:0]     nib     = 4'h0;
  logic           inj     = 1'b0;
  logic           tx_en;
  logic           tx_er;
  logic           tx_en_o;
  logic           tx_er_o;
  logic [1:0]     pend    = 2'b00;
  int             miscompares = 0;
  int             checked     = 0;
  int             en_cnt      = 0;
  int             er_cnt      = 0;
  int             gap;

  always #10 clk = ~clk;

  pcr_ctrl_regs #(
    .LINK_DROP_CYC (LDROP),
    .RECOVERY_CYC  (RCV),
    .XOVER_CYC     (XOV)
  ) pcr_ctrl_regs_inst (
    .clk                      (clk),
    .sys_rst                  (sys_rst),
    .reg_req                  (req),
    .reg_rdata                (rdata),
    .standard_pinout_mode     (mode),
    .configuration_strap_one  (strap),
    .signal_ok                (sig_ok),
    .link_up                  (link_up),
    .auto_cable_reflectometry (cable_start),
    .mdix_sel                 (mdix_sel),
    .an_enable                (an_en),
    .forced_100               (f100),
    .partner_forced_100       (pf100),
    .std_full_duplex          (std_fdx),
    .full_duplex              (fdx),
    .rx_sym                   (rx_sym),
    .rx_dv                    (rx_dv),
    .rx_er                    (rx_er),
    .tx_en_in                 (tx_en),
    .tx_er_in                 (tx_er),
    .tx_en_out                (tx_en_o),
    .tx_er_out                (tx_er_o)
  );

  pcr_mac_model pcr_mac_model_inst (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .start      (start),
    .nibbles    (nib),
    .inject_err (inj),
    .tx_en      (tx_en),
    .tx_er      (tx_er)
  );

  // transmit output counters
  always @(negedge clk) begin
    en_cnt += int'(tx_en_o);
    er_cnt += int'(tx_er_o);
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic m, input logic s);
    @(posedge clk);
    sys_rst <= 1'b1;
    mode    <= m;
    strap   <= s;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic reg_write(input pcr_addr_type a, input pcr_data_type d);
    @(posedge clk);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clk);
    req.wr    <= 1'b0;
  endtask

  task automatic reg_read(input pcr_addr_type a, input pcr_data_type exp);
    @(posedge clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk);
    req.rd   <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  // e = {rx_dv, rx_er} expected after this symbol
  task automatic rx_step(input logic v, input pcr_sym_type c,
                         input logic [1:0] e);
    @(posedge clk);
    rx_sym <= pcr_rx_sym_type'({v, c});
    #1;
    check({14'h0, rx_dv, rx_er}, {14'h0, pend});
    pend = e;
  endtask

  task automatic tx_burst(input logic [3:0] n, input logic err,
                          input logic ext);
    @(posedge clk);
    en_cnt = 0;
    er_cnt = 0;
    start <= 1'b1;
    nib   <= n;
    inj   <= err;
    @(posedge clk);
    start <= 1'b0;
    repeat (int'(n) + 4) @(posedge clk);
    check(16'(en_cnt), 16'(n) + 16'(ext));
    check(16'(er_cnt), 16'(err) + 16'(ext));
  endtask

  task automatic link_drop(input int exp_n, input logic exp_pulse);
    int   n;
    logic pulse;
    @(posedge clk);
    sig_ok <= 1'b0;
    n = 0;
    pulse = 1'b0;
    do begin
      @(posedge clk);
      #1;
      n++;
      pulse = cable_start;
    end while (link_up === 1'b1 && n < 400);
    check(16'(n), 16'(exp_n));
    check({15'h0, pulse}, {15'h0, exp_pulse});
    @(posedge clk);
    sig_ok <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task automatic xover_gap(output int g);
    logic prev;
    int   n;
    @(posedge clk);
    #1;
    prev = mdix_sel;
    n = 0;
    while (mdix_sel === prev && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    prev = mdix_sel;
    g = 0;
    while (mdix_sel === prev && g < 400) begin
      @(posedge clk);
      #1;
      g++;
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    give_verdict();
  end

  initial begin
    do_reset(1'b0, 1'b1);
    reg_read(`PCR_OFF_CTRL_ONE, 16'h0000);
    reg_read(`PCR_OFF_CTRL_TWO, 16'h0102);
    reg_read(5'h0B, 16'h0000);
    reg_write(`PCR_OFF_CTRL_ONE, 16'hFFFF);
    reg_read(`PCR_OFF_CTRL_ONE, 16'h03FE);
    reg_write(`PCR_OFF_CTRL_TWO, 16'hFFFF);
    reg_read(`PCR_OFF_CTRL_TWO, 16'hFFFF);
    do_reset(1'b0, 1'b0);
    reg_read(`PCR_OFF_CTRL_TWO, 16'h0100);
    do_reset(1'b1, 1'b0);
    reg_read(`PCR_OFF_CTRL_TWO, 16'h0102);
    xover_gap(gap);
    check(16'(gap), 16'(XOV + 1));
    reg_write(`PCR_OFF_CTRL_ONE, 16'h0020);
    xover_gap(gap);
    check({15'h0, gap >= XOV + 1 && gap <= XOV + 256}, 16'h0001);
    @(posedge clk);
    sig_ok <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check({15'h0, link_up}, 16'h0001);
    reg_write(`PCR_OFF_CTRL_ONE, 16'h0100);
    link_drop(LDROP + 2, 1'b1);
    @(posedge clk);
    sig_ok <= 1'b0;
    repeat (LDROP / 2) @(posedge clk);
    sig_ok <= 1'b1;
    repeat (LDROP * 2) @(posedge clk);
    #1;
    check({15'h0, link_up}, 16'h0001);
    reg_write(`PCR_OFF_CTRL_ONE, 16'h0080);
    link_drop(LDROP + RCV + 2, 1'b0);
    reg_write(`PCR_OFF_CTRL_ONE, 16'h0020);
    for (int i = 0; i < 32; i++) begin
      reg_write(`PCR_OFF_CTRL_TWO, i[4] ? 16'h0122 : 16'h0102);
      an_en   <= i[3];
      f100    <= i[2];
      pf100   <= i[1];
      std_fdx <= i[0];
      repeat (2) @(posedge clk);
      #1;
      check({15'h0, fdx}, {15'h0, (i[4] & (i[3] | i[2]) & i[1]) | i[0]});
    end
    reg_write(`PCR_OFF_CTRL_TWO, 16'h0100);
    tx_burst(4'h3, 1'b0, 1'b1);
    tx_burst(4'h4, 1'b0, 1'b0);
    tx_burst(4'h3, 1'b1, 1'b1);
    reg_write(`PCR_OFF_CTRL_TWO, 16'h0102);
    tx_burst(4'h3, 1'b0, 1'b0);
    reg_write(`PCR_OFF_CTRL_ONE, 16'h0000);
    rx_step(1'b1, PCR_SYM_J, 2'b00);
    rx_step(1'b1, PCR_SYM_K, 2'b10);
    rx_step(1'b1, PCR_SYM_DATA, 2'b10);
    rx_step(1'b1, PCR_SYM_T, 2'b00);
    rx_step(1'b0, PCR_SYM_IDLE, 2'b00);
    reg_write(`PCR_OFF_CTRL_ONE, 16'h0002);
    rx_step(1'b1, PCR_SYM_J, 2'b10);
    rx_step(1'b1, PCR_SYM_K, 2'b10);
    rx_step(1'b1, PCR_SYM_T, 2'b00);
    rx_step(1'b1, PCR_SYM_J, 2'b10);
    rx_step(1'b1, PCR_SYM_DATA, 2'b01);
    rx_step(1'b1, PCR_SYM_IDLE, 2'b00);
    rx_step(1'b0, PCR_SYM_IDLE, 2'b00);
    reg_write(`PCR_OFF_CTRL_TWO, 16'h0106);
    rx_step(1'b1, PCR_SYM_BAD, 2'b01);
    rx_step(1'b0, PCR_SYM_IDLE, 2'b00);
    reg_write(`PCR_OFF_CTRL_TWO, 16'h0102);
    rx_step(1'b1, PCR_SYM_BAD, 2'b00);
    rx_step(1'b0, PCR_SYM_IDLE, 2'b00);
    rx_step(1'b0, PCR_SYM_IDLE, 2'b00);
    give_verdict();
  end
endmodule

`default_nettype wire
